// >>> verilog/cbl_exec.sv
// Execution unit for bit-set, relative call, flag clears, clear/complement/decrement, compare, XOR
`include "cbl_map.svh"
// Function
// - Bit-set writes one to bit n, five cycles
// - Bit-set targets direct page, flags unchanged
// - Relative call return address is opcode plus two
// - Push low return byte, then high, decrementing
// - Call loads PC with return plus offset
// - Clear-carry zeroes carry only, two cycles
// - Clear-mask zeroes interrupt mask, two cycles
// - Interrupts held off after mask clear; next instruction runs first
// - Clear writes zero to register or memory
// - Compare subtracts memory from accumulator, flags only
// - Compares write only negative, zero, carry
// - Compare carry is unsigned borrow formula
// - Compare-index subtracts memory from index register
// - Complement inverts target and sets carry
// - Decrement subtracts one, updates negative, zero
// - Decrement leaves carry unchanged
// - Exclusive-OR of accumulator and memory
// - Negative is bit seven, zero when all clear
// - Register-memory cycle counts per addressing mode
// - Read-modify-write cycle counts per addressing mode
// - Relative targets use signed eight-bit offset
module cbl_exec (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 issue_valid,
  input  cbl_pkg::cbl_instr_t       issue,
  output logic                      issue_ready,
  output logic                      done,
  output logic                      pc_load,
  output logic                      pass_valid,
  output cbl_pkg::cbl_instr_t       pass_instr,
  output cbl_pkg::cbl_mem_req_t     mem_req,
  input  wire logic [7:0]           mem_rdata,
  input  wire logic                 irq_pending,
  output logic                      irq_take,
  output logic [7:0]                acc,
  output logic [7:0]                idx,
  output logic [15:0]               sp,
  output logic [15:0]               pc,
  output cbl_pkg::cbl_flags_t       flags
);
  cbl_pkg::cbl_dec_t     dec_in;
  cbl_pkg::cbl_dec_t     dec_q,   dec_d;
  cbl_pkg::cbl_st_t      state_q, state_d;
  cbl_pkg::cbl_instr_t   ins_q,   ins_d;
  cbl_pkg::cbl_instr_t   pass_q,  pass_d;
  cbl_pkg::cbl_mem_req_t mem_q,   mem_d;
  cbl_pkg::cbl_flags_t   flags_q, flags_d;
  cbl_pkg::cbl_flags_t   alu_f;
  logic [2:0]            cnt_q,   cnt_d;
  logic [7:0]            mdata_q, mdata_d;
  logic [7:0]            acc_q,   acc_d;
  logic [7:0]            idx_q,   idx_d;
  logic [15:0]           sp_q,    sp_d;
  logic [15:0]           pc_q,    pc_d;
  logic [31:0]           count_q, count_d;
  logic [31:0]           rd_q,    rd_d;
  logic                  pv_q,    pv_d;
  logic                  hold_q,  hold_d;
  logic                  en_q,    en_d;
  logic                  err_q,   err_d;
  logic                  accept;
  logic                  last;
  logic [7:0]            alu_a;
  logic [7:0]            alu_m;
  logic [7:0]            alu_res;
  logic [15:0]           ret;

  function automatic logic [15:0] eff_addr(input cbl_pkg::cbl_mode_t mode,
                                           input cbl_pkg::cbl_instr_t ins,
                                           input logic [7:0] x);
    case (mode)
      cbl_pkg::M_DIR: eff_addr = {8'h00, ins.op1};
      cbl_pkg::M_EXT: eff_addr = {ins.op1, ins.op2};
      cbl_pkg::M_IX:  eff_addr = {8'h00, x};
      cbl_pkg::M_IX1: eff_addr = {8'h00, ins.op1} + {8'h00, x};
      cbl_pkg::M_IX2: eff_addr = {ins.op1, ins.op2} + {8'h00, x};
      default:        eff_addr = 16'h0000;
    endcase
  endfunction

  function automatic logic in_mem(input cbl_pkg::cbl_dec_t d);
    in_mem = (d.mode == cbl_pkg::M_DIR) || (d.mode == cbl_pkg::M_EXT) ||
             (d.mode == cbl_pkg::M_IX) || (d.mode == cbl_pkg::M_IX1) ||
             (d.mode == cbl_pkg::M_IX2);
  endfunction

  function automatic logic mem_store(input cbl_pkg::cbl_dec_t d);
    mem_store = in_mem(d) && ((d.op == cbl_pkg::OP_SET_MEMORY_BIT) || (d.op == cbl_pkg::OP_CLR) ||
                              (d.op == cbl_pkg::OP_COM) || (d.op == cbl_pkg::OP_DEC));
  endfunction

  cbl_decode u_decode (
    .opcode (issue.opcode),
    .dec    (dec_in)
  );

  cbl_alu u_alu (
    .op    (dec_q.op),
    .a     (alu_a),
    .m     (alu_m),
    .bitn  (ins_q.opcode[3:1]),
    .f_in  (flags_q),
    .res   (alu_res),
    .f_out (alu_f)
  );

  // Interrupts wait while masked or during the shadow after a mask clear
  assign irq_take    = (state_q == cbl_pkg::ST_IDLE) && irq_pending &&
                       !flags_q.i && !hold_q;
  assign issue_ready = (state_q == cbl_pkg::ST_IDLE) && en_q && !irq_take;
  assign accept      = issue_valid && issue_ready && (dec_in.op != cbl_pkg::OP_NONE);
  assign last        = (state_q == cbl_pkg::ST_EXEC) && (cnt_q == 3'h1);
  assign done        = last;
  assign pc_load     = last && (dec_q.op == cbl_pkg::OP_BSR);
  assign ret         = ins_q.pc + `CBL_RET_OFS;

  always_comb begin
    alu_m = (dec_q.mode == cbl_pkg::M_IMM) ? ins_q.op1 : mdata_q;
    case (dec_q.op)
      cbl_pkg::OP_CMP, cbl_pkg::OP_EOR: alu_a = acc_q;
      cbl_pkg::OP_CPX: alu_a = idx_q;
      default: begin
        if (dec_q.mode == cbl_pkg::M_INH_A) begin
          alu_a = acc_q;
        end else if (dec_q.mode == cbl_pkg::M_INH_X) begin
          alu_a = idx_q;
        end else begin
          alu_a = mdata_q;
        end
      end
    endcase
  end

  // Sequencer: cycle count, operand capture and bus requests
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    dec_d   = dec_q;
    ins_d   = ins_q;
    mdata_d = mdata_q;
    mem_d   = '{re: 1'b0, we: 1'b0, addr: 16'h0000, wdata: 8'h00};
    pv_d    = issue_valid && issue_ready && (dec_in.op == cbl_pkg::OP_NONE);
    pass_d  = pv_d ? issue : pass_q;
    if (accept) begin
      state_d = cbl_pkg::ST_EXEC;
      cnt_d   = dec_in.ncyc;
      dec_d   = dec_in;
      ins_d   = issue;
      if (dec_in.op == cbl_pkg::OP_BSR) begin
        mem_d = '{re: 1'b0, we: 1'b1, addr: sp_q,
                  wdata: 8'(issue.pc + `CBL_RET_OFS)};
      end else if (in_mem(dec_in) && (dec_in.op != cbl_pkg::OP_CLR)) begin
        mem_d = '{re: 1'b1, we: 1'b0, addr: eff_addr(dec_in.mode, issue, idx_q),
                  wdata: 8'h00};
      end
    end else if (state_q == cbl_pkg::ST_EXEC) begin
      cnt_d = cnt_q - 3'h1;
      if (last) begin
        state_d = cbl_pkg::ST_IDLE;
      end
      if ((dec_q.op == cbl_pkg::OP_BSR) && (cnt_q == dec_q.ncyc)) begin
        mem_d = '{re: 1'b0, we: 1'b1, addr: sp_q - 16'h0001, wdata: ret[15:8]};
      end
      if (cnt_q == dec_q.ncyc - 3'h1) begin
        mdata_d = mem_rdata;
      end
      if (mem_store(dec_q) && (cnt_q == 3'h2)) begin
        mem_d = '{re: 1'b0, we: 1'b1, addr: eff_addr(dec_q.mode, ins_q, idx_q),
                  wdata: alu_res};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= cbl_pkg::ST_IDLE;
      cnt_q   <= 3'h0;
      dec_q   <= '{op: cbl_pkg::OP_NONE, mode: cbl_pkg::M_INH_A, ncyc: 3'h0};
      ins_q   <= '0;
      mdata_q <= 8'h00;
      mem_q   <= '0;
      pv_q    <= 1'b0;
      pass_q  <= '0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      dec_q   <= dec_d;
      ins_q   <= ins_d;
      mdata_q <= mdata_d;
      mem_q   <= mem_d;
      pv_q    <= pv_d;
      pass_q  <= pass_d;
    end
  end

  // Programmer-visible state, committed in the last cycle of an instruction
  always_comb begin
    acc_d   = acc_q;
    idx_d   = idx_q;
    sp_d    = sp_q;
    pc_d    = pc_q;
    flags_d = flags_q;
    count_d = count_q;
    hold_d  = hold_q;
    if (pv_q) begin
      hold_d = 1'b0;
    end
    if (last) begin
      count_d = count_q + 32'h1;
      flags_d = alu_f;
      hold_d  = 1'b0;
      case (dec_q.op)
        cbl_pkg::OP_BSR: begin
          sp_d = sp_q - `CBL_RET_OFS;
          pc_d = ret + {{8{ins_q.op1[7]}}, ins_q.op1};
        end
        cbl_pkg::OP_CLI: begin
          flags_d.i = 1'b0;
          hold_d    = 1'b1;
        end
        cbl_pkg::OP_EOR: acc_d = alu_res;
        cbl_pkg::OP_CLR, cbl_pkg::OP_COM, cbl_pkg::OP_DEC: begin
          if (dec_q.mode == cbl_pkg::M_INH_A) begin
            acc_d = alu_res;
          end else if (dec_q.mode == cbl_pkg::M_INH_X) begin
            idx_d = alu_res;
          end
        end
        default: flags_d = alu_f;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q   <= 8'h00;
      idx_q   <= 8'h00;
      sp_q    <= `CBL_SP_RST;
      pc_q    <= `CBL_PC_RST;
      flags_q <= `CBL_FLAGS_RST;
      count_q <= 32'h0;
      hold_q  <= 1'b0;
    end else begin
      acc_q   <= acc_d;
      idx_q   <= idx_d;
      sp_q    <= sp_d;
      pc_q    <= pc_d;
      flags_q <= flags_d;
      count_q <= count_d;
      hold_q  <= hold_d;
    end
  end

  // APB slave: read data latched in the setup cycle, no wait states
  always_comb begin
    en_d  = en_q;
    rd_d  = rd_q;
    err_d = err_q;
    if (psel && !penable) begin
      err_d = 1'b0;
      case (paddr)
        `CBL_A_CTRL:  rd_d = {31'h0, en_q};
        `CBL_A_FLAGS: rd_d = {27'h0, flags_q};
        `CBL_A_REGS:  rd_d = {sp_q, idx_q, acc_q};
        `CBL_A_PC:    rd_d = {16'h0000, pc_q};
        `CBL_A_COUNT: rd_d = count_q;
        default: begin
          rd_d  = 32'h0;
          err_d = 1'b1;
        end
      endcase
    end
    if (psel && penable && pwrite && (paddr == `CBL_A_CTRL)) begin
      en_d = pwdata[`CBL_CTRL_EN];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q  <= `CBL_EN_RST;
      rd_q  <= 32'h0;
      err_q <= 1'b0;
    end else begin
      en_q  <= en_d;
      rd_q  <= rd_d;
      err_q <= err_d;
    end
  end

  assign prdata     = rd_q;
  assign pready     = 1'b1;
  assign pslverr    = psel && penable && err_q;
  assign mem_req    = mem_q;
  assign pass_valid = pv_q;
  assign pass_instr = pass_q;
  assign acc        = acc_q;
  assign idx        = idx_q;
  assign sp         = sp_q;
  assign pc         = pc_q;
  assign flags      = flags_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_set_memory_bit_cycles: assert property (accept && dec_in.op == cbl_pkg::OP_SET_MEMORY_BIT |-> ##5 done)
    else $error("bit-set did not take five cycles");
  a_set_memory_bit_flags: assert property (accept && dec_in.op == cbl_pkg::OP_SET_MEMORY_BIT
                                 |=> $stable(flags_q)[*5])
    else $error("bit-set changed flags");
  a_bsr_push: assert property (accept && dec_in.op == cbl_pkg::OP_BSR |=>
      mem_q.we && mem_q.addr == $past(sp_q) ##1 mem_q.we && mem_q.addr == sp_q - 16'h0001
      ##1 !mem_q.we ##1 sp == $past(sp_q, 3) - 16'h0002)
    else $error("call push sequence wrong");
  a_bsr_target: assert property (pc_load |=> pc_q == $past(ret) +
                                 {{8{$past(ins_q.op1[7])}}, $past(ins_q.op1)})
    else $error("call target wrong");
  a_clc_carry: assert property (accept && dec_in.op == cbl_pkg::OP_CLC
                                |-> ##2 done ##1 !flags_q.c)
    else $error("carry clear wrong");
  a_cli_shadow: assert property (done && dec_q.op == cbl_pkg::OP_CLI
                                 |=> !flags_q.i && !irq_take)
    else $error("interrupt taken in mask shadow");
  a_cmp_keeps: assert property (accept && dec_in.op == cbl_pkg::OP_CMP
                                |=> $stable(acc_q)[*2])
    else $error("compare changed accumulator");
  a_com_carry: assert property (done && dec_q.op == cbl_pkg::OP_COM |=> flags_q.c)
    else $error("complement left carry clear");
  a_dec_carry: assert property (done && dec_q.op == cbl_pkg::OP_DEC
                                |=> flags_q.c == $past(flags_q.c))
    else $error("decrement changed carry");
  a_eor_flags: assert property (done && dec_q.op == cbl_pkg::OP_EOR
                                |=> flags_q.n == acc_q[7] && flags_q.z == (acc_q == 8'h00))
    else $error("exclusive-or flags wrong");
  a_ix2_cycles: assert property (accept && dec_in.mode == cbl_pkg::M_IX2 |-> ##5 done)
    else $error("16-bit offset operation not five cycles");
  a_clr_flags: assert property (done && dec_q.op == cbl_pkg::OP_CLR
                                |=> flags_q.z && !flags_q.n)
    else $error("clear flags wrong");
  a_pass_only: assert property (pv_q |-> state_q == cbl_pkg::ST_IDLE && !mem_q.we)
    else $error("foreign opcode acted upon");

  c_bsr: cover property (pc_load);
  c_cli_irq: cover property (done && dec_q.op == cbl_pkg::OP_CLI ##[1:8] irq_take);
  c_rmw_mem: cover property (mem_q.we && dec_q.op == cbl_pkg::OP_DEC);
endmodule

// >>> verilog/cbl_map.svh
// Opcode fields, cycle counts, register offsets and reset values of the execution block
`ifndef CBL_MAP_SVH
`define CBL_MAP_SVH
`define CBL_OPC_BSR   8'hAD
`define CBL_OPC_CLC   8'h98
`define CBL_OPC_CLI   8'h9A
`define CBL_HI_SET_MEMORY_BIT   4'h1
`define CBL_HI_DIR    4'h3
`define CBL_HI_A      4'h4
`define CBL_HI_X      4'h5
`define CBL_HI_IX1    4'h6
`define CBL_HI_IX     4'h7
`define CBL_HI_IMM    4'hA
`define CBL_HI_RDIR   4'hB
`define CBL_HI_EXT    4'hC
`define CBL_HI_IX2    4'hD
`define CBL_HI_RIX1   4'hE
`define CBL_HI_RIX    4'hF
`define CBL_LO_CLR    4'hF
`define CBL_LO_COM    4'h3
`define CBL_LO_DEC    4'hA
`define CBL_LO_CMP    4'h1
`define CBL_LO_CPX    4'h3
`define CBL_LO_EOR    4'h8
`define CBL_CYC_SET_MEMORY_BIT  3'h5
`define CBL_CYC_BSR   3'h3
`define CBL_CYC_FLAG  3'h2
`define CBL_CYC_IMM   3'h2
`define CBL_CYC_RDIR  3'h3
`define CBL_CYC_EXT   3'h4
`define CBL_CYC_RIX   3'h3
`define CBL_CYC_RIX1  3'h4
`define CBL_CYC_IX2   3'h5
`define CBL_CYC_INH   3'h3
`define CBL_CYC_DIR   3'h5
`define CBL_CYC_IX    3'h5
`define CBL_CYC_IX1   3'h6
`define CBL_RET_OFS   16'h0002
`define CBL_BYTE_ONE  8'h01
`define CBL_A_CTRL    8'h00
`define CBL_A_FLAGS   8'h04
`define CBL_A_REGS    8'h08
`define CBL_A_PC      8'h0C
`define CBL_A_COUNT   8'h10
`define CBL_CTRL_EN   0
`define CBL_SP_RST    16'h00FF
`define CBL_PC_RST    16'h0000
`define CBL_EN_RST    1'h1
`define CBL_FLAGS_RST 5'h08
`endif

// >>> verilog/cbl_pkg.sv
// Types shared by the execution block
package cbl_pkg;
  typedef enum logic [3:0] {
    OP_NONE, OP_SET_MEMORY_BIT, OP_BSR, OP_CLC, OP_CLI, OP_CLR, OP_COM, OP_DEC, OP_CMP, OP_CPX, OP_EOR
  } cbl_op_t;
  typedef enum logic [3:0] {
    M_INH_A, M_INH_X, M_IMM, M_DIR, M_EXT, M_IX, M_IX1, M_IX2, M_REL
  } cbl_mode_t;
  typedef enum logic [0:0] {ST_IDLE, ST_EXEC} cbl_st_t;
  typedef struct packed {
    cbl_op_t   op;
    cbl_mode_t mode;
    logic [2:0] ncyc;
  } cbl_dec_t;
  typedef struct packed {
    logic [7:0]  opcode;
    logic [7:0]  op1;
    logic [7:0]  op2;
    logic [15:0] pc;
  } cbl_instr_t;
  typedef struct packed {
    logic        re;
    logic        we;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } cbl_mem_req_t;
  typedef struct packed {
    logic h;
    logic i;
    logic n;
    logic z;
    logic c;
  } cbl_flags_t;
endpackage

// >>> verilog/cbl_decode.sv
// Opcode decoder: instruction class, addressing mode and cycle count
`include "cbl_map.svh"
module cbl_decode (
  input  wire logic [7:0]       opcode,
  output cbl_pkg::cbl_dec_t     dec
);
  logic [3:0] hi;
  logic [3:0] lo;
  assign hi = opcode[7:4];
  assign lo = opcode[3:0];

  always_comb begin
    dec = '{op: cbl_pkg::OP_NONE, mode: cbl_pkg::M_INH_A, ncyc: 3'h0};
    if (opcode == `CBL_OPC_BSR) begin
      dec = '{op: cbl_pkg::OP_BSR, mode: cbl_pkg::M_REL, ncyc: `CBL_CYC_BSR};
    end else if (opcode == `CBL_OPC_CLC) begin
      dec = '{op: cbl_pkg::OP_CLC, mode: cbl_pkg::M_INH_A, ncyc: `CBL_CYC_FLAG};
    end else if (opcode == `CBL_OPC_CLI) begin
      dec = '{op: cbl_pkg::OP_CLI, mode: cbl_pkg::M_INH_A, ncyc: `CBL_CYC_FLAG};
    end else begin
      case (hi)
        `CBL_HI_SET_MEMORY_BIT: begin
          if (!opcode[0]) begin
            dec = '{op: cbl_pkg::OP_SET_MEMORY_BIT, mode: cbl_pkg::M_DIR, ncyc: `CBL_CYC_SET_MEMORY_BIT};
          end
        end
        `CBL_HI_DIR, `CBL_HI_A, `CBL_HI_X, `CBL_HI_IX1, `CBL_HI_IX: begin
          case (lo)
            `CBL_LO_CLR: dec.op = cbl_pkg::OP_CLR;
            `CBL_LO_COM: dec.op = cbl_pkg::OP_COM;
            `CBL_LO_DEC: dec.op = cbl_pkg::OP_DEC;
            default:     dec.op = cbl_pkg::OP_NONE;
          endcase
          case (hi)
            `CBL_HI_DIR: dec.mode = cbl_pkg::M_DIR;
            `CBL_HI_A:   dec.mode = cbl_pkg::M_INH_A;
            `CBL_HI_X:   dec.mode = cbl_pkg::M_INH_X;
            `CBL_HI_IX1: dec.mode = cbl_pkg::M_IX1;
            default:     dec.mode = cbl_pkg::M_IX;
          endcase
          case (hi)
            `CBL_HI_DIR: dec.ncyc = `CBL_CYC_DIR;
            `CBL_HI_IX1: dec.ncyc = `CBL_CYC_IX1;
            `CBL_HI_IX:  dec.ncyc = `CBL_CYC_IX;
            default:     dec.ncyc = `CBL_CYC_INH;
          endcase
        end
        `CBL_HI_IMM, `CBL_HI_RDIR, `CBL_HI_EXT, `CBL_HI_IX2, `CBL_HI_RIX1, `CBL_HI_RIX: begin
          case (lo)
            `CBL_LO_CMP: dec.op = cbl_pkg::OP_CMP;
            `CBL_LO_CPX: dec.op = cbl_pkg::OP_CPX;
            `CBL_LO_EOR: dec.op = cbl_pkg::OP_EOR;
            default:     dec.op = cbl_pkg::OP_NONE;
          endcase
          case (hi)
            `CBL_HI_IMM:  dec = '{op: dec.op, mode: cbl_pkg::M_IMM, ncyc: `CBL_CYC_IMM};
            `CBL_HI_RDIR: dec = '{op: dec.op, mode: cbl_pkg::M_DIR, ncyc: `CBL_CYC_RDIR};
            `CBL_HI_EXT:  dec = '{op: dec.op, mode: cbl_pkg::M_EXT, ncyc: `CBL_CYC_EXT};
            `CBL_HI_IX2:  dec = '{op: dec.op, mode: cbl_pkg::M_IX2, ncyc: `CBL_CYC_IX2};
            `CBL_HI_RIX1: dec = '{op: dec.op, mode: cbl_pkg::M_IX1, ncyc: `CBL_CYC_RIX1};
            default:      dec = '{op: dec.op, mode: cbl_pkg::M_IX, ncyc: `CBL_CYC_RIX};
          endcase
        end
        default: dec.op = cbl_pkg::OP_NONE;
      endcase
      if (dec.op == cbl_pkg::OP_NONE) begin
        dec = '{op: cbl_pkg::OP_NONE, mode: cbl_pkg::M_INH_A, ncyc: 3'h0};
      end
    end
  end
endmodule

// >>> verilog/cbl_alu.sv
// Result and flag computation for the instruction group
`include "cbl_map.svh"
module cbl_alu (
  input  cbl_pkg::cbl_op_t    op,
  input  wire logic [7:0]     a,
  input  wire logic [7:0]     m,
  input  wire logic [2:0]     bitn,
  input  cbl_pkg::cbl_flags_t f_in,
  output logic [7:0]          res,
  output cbl_pkg::cbl_flags_t f_out
);
  logic nz;

  always_comb begin
    res   = a;
    f_out = f_in;
    nz    = 1'b1;
    case (op)
      cbl_pkg::OP_SET_MEMORY_BIT: begin
        res = m | (`CBL_BYTE_ONE << bitn);
        nz  = 1'b0;
      end
      cbl_pkg::OP_CLC: begin
        f_out.c = 1'b0;
        nz      = 1'b0;
      end
      cbl_pkg::OP_CLR: begin
        res = 8'h00;
        nz  = 1'b1;
      end
      cbl_pkg::OP_COM: begin
        res     = ~a;
        f_out.c = 1'b1;
      end
      cbl_pkg::OP_DEC: res = a - `CBL_BYTE_ONE;
      cbl_pkg::OP_CMP, cbl_pkg::OP_CPX: begin
        res     = a - m;
        f_out.c = (~a[7] & m[7]) | (m[7] & res[7]) | (res[7] & ~a[7]);
      end
      cbl_pkg::OP_EOR: res = a ^ m;
      default: nz = 1'b0;
    endcase
    if (nz) begin
      f_out.n = res[7];
      f_out.z = (res == 8'h00);
    end
  end
endmodule

// >>> testbench/cbl_mem_model.sv
// Byte memory and I/O space on the core bus of the execution block
module cbl_mem_model (
  input wire logic              pclk,
  input cbl_pkg::cbl_mem_req_t  req,
  output logic [7:0]            rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] bytes [0:65535];
  initial rdata = 8'h00;
  // Read data is valid one cycle only, then turns over so a stale sample shows
  always @(posedge pclk) begin
    if (req.we)
      bytes[req.addr] <= req.wdata;
    rdata <= req.re ? bytes[req.addr] : ~rdata;
  end
endmodule

// >>> testbench/test_cpu_bitset_compare_logic_ops.sv
// Bench for the instruction-group execution block
module test_cpu_bitset_compare_logic_ops;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0;
  logic [7:0]            paddr = '0, mem_rdata, acc, idx;
  logic [31:0]           pwdata = '0, prdata, rd;
  logic                  pready, pslverr, issue_valid = '0, issue_ready, done, pc_load;
  logic                  pass_valid, irq_pending = '0, irq_take, ld, se;
  logic [15:0]           sp, pc;
  cbl_pkg::cbl_instr_t   issue = '0, pass_instr;
  cbl_pkg::cbl_mem_req_t mem_req;
  cbl_pkg::cbl_flags_t   flags;
  int                    n_mismatch = 0, n_tests = 0, n_ret = 0, cyc = 0;

  always #2.5 pclk = ~pclk;
  cbl_exec dut (.*);
  cbl_mem_model far (.pclk(pclk), .req(mem_req), .rdata(mem_rdata));

  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (cyc > 3000) begin
      n_mismatch++;
      tally_and_finish;
    end
  end

  task automatic chk(input logic [47:0] s, input logic [47:0] e);
    n_tests++;
    if (s !== e) begin
      n_mismatch++;
      $display("ERROR at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  // Flags of register minus memory: negative, zero, borrow
  function automatic logic [2:0] nzc(input logic [7:0] a, input logic [7:0] m);
    logic [7:0] r;
    r = a - m;
    return {r[7], r == 8'h00, (~a[7] & m[7]) | (m[7] & r[7]) | (r[7] & ~a[7])};
  endfunction

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'h1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    se = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask

  task automatic offer(input logic [7:0] o, p1, p2, input logic [15:0] a);
    issue       <= {o, p1, p2, a};
    issue_valid <= 1'h1;
    do @(posedge pclk); while (issue_ready !== 1'h1);
    issue_valid <= 1'h0;
  endtask

  task automatic run(input logic [7:0] o, p1, p2, input logic [15:0] a, input int n);
    int k;
    k = 0;
    offer(o, p1, p2, a);
    do begin
      @(negedge pclk);
      k++;
    end while (done !== 1'h1 && k < 9);
    ld = pc_load;
    @(posedge pclk);
    @(negedge pclk);
    chk(k, n);
    chk(ld, o == 8'hAD);
    n_ret++;
    @(posedge pclk);
  endtask

  task automatic t_apb;
    apb(1'h0, 8'h04, '0);
    chk(rd, 32'h08);
    apb(1'h0, 8'h08, '0);
    chk(rd, 32'h00FF_0000);
    apb(1'h0, 8'h40, '0);
    chk({se, rd}, {1'h1, 32'h0});
    apb(1'h1, 8'h00, '0);
    apb(1'h0, 8'h00, '0);
    chk({rd, issue_ready}, {32'h0, 1'h0});
    apb(1'h1, 8'h00, 32'h1);
  endtask

  task automatic t_set_memory_bit;
    far.bytes[16'h0040] = 8'h00;
    for (int n = 0; n < 8; n++) begin
      run(8'h10 + 8'(2 * n), 8'h40, 8'h00, 16'h0100, 5);
      chk(far.bytes[16'h0040], 8'hFF >> (7 - n));
      chk(flags, 5'h08);
    end
  endtask

  task automatic t_cmp;
    logic [55:0] t [6] = '{56'hA1_80_00_80_02_0050, 56'hB1_41_00_81_03_0041,
      56'hC1_12_34_01_04_1234, 56'hF1_00_00_7F_03_0000, 56'hE1_11_00_00_04_0011,
      56'hD1_12_FF_FF_05_12FF};
    run(8'hA8, 8'h80, 8'h00, 16'h0100, 2);
    chk({acc, flags}, {8'h80, 5'h0C});
    foreach (t[i]) begin
      far.bytes[t[i][15:0]] = t[i][31:24];
      run(t[i][55:48], t[i][47:40], t[i][39:32], 16'h0100, t[i][23:16]);
      chk({acc, flags}, {8'h80, 2'h1, nzc(8'h80, t[i][31:24])});
    end
    run(8'hA3, 8'h01, 8'h00, 16'h0100, 2);
    chk({idx, flags}, {8'h00, 2'h1, nzc(8'h00, 8'h01)});
  endtask

  task automatic t_rmw;
    logic [63:0] t [13] = '{64'h4F_00_03_00_00_42_01_0B, 64'h98_00_02_00_00_42_01_0A,
      64'h43_00_03_FF_00_42_01_0D, 64'h4A_00_03_FE_00_42_01_0D, 64'h53_00_03_FE_FF_42_01_0D,
      64'h5A_00_03_FE_FE_42_01_0D, 64'h5F_00_03_FE_00_42_01_0B, 64'h3A_42_05_FE_00_42_00_0B,
      64'h33_42_05_FE_00_42_FF_0D, 64'h3F_42_05_FE_00_42_00_0B, 64'h7A_00_05_FE_00_00_7E_09,
      64'h73_00_05_FE_00_00_81_0D, 64'h6F_10_06_FE_00_10_00_0B};
    far.bytes[16'h0042] = 8'h01;
    far.bytes[16'h0010] = 8'h55;
    foreach (t[i]) begin
      run(t[i][63:56], t[i][55:48], 8'h00, 16'h0100, t[i][47:40]);
      chk({acc, idx}, t[i][39:24]);
      chk(far.bytes[{8'h00, t[i][23:16]}], t[i][15:8]);
      chk(flags, t[i][4:0]);
    end
  endtask

  task automatic t_call;
    run(8'hAD, 8'hF0, 8'h00, 16'h1380, 3);
    chk({far.bytes[16'h00FF], far.bytes[16'h00FE]}, 16'h8213);
    chk({sp, pc, flags}, {32'h00FD_1372, 5'h0B});
  endtask

  task automatic t_mask;
    irq_pending <= 1'h1;
    run(8'h9A, 8'h00, 8'h00, 16'h0100, 2);
    chk({flags, irq_take}, {5'h03, 1'h0});
    run(8'h98, 8'h00, 8'h00, 16'h0101, 2);
    chk({flags, irq_take}, {5'h02, 1'h1});
    irq_pending <= 1'h0;
  endtask

  task automatic t_pass;
    offer(8'hA6, 8'h5A, 8'h00, 16'h0300);
    @(negedge pclk);
    chk({pass_valid, pass_instr}, {1'h1, 40'hA6_5A_00_0300});
    chk({acc, flags, done}, {8'hFE, 5'h02, 1'h0});
    @(posedge pclk);
  endtask

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    t_apb;
    t_set_memory_bit;
    t_cmp;
    t_rmw;
    t_call;
    t_mask;
    t_pass;
    apb(1'h0, 8'h10, '0);
    chk(rd, n_ret);
    tally_and_finish;
  end
endmodule
